// ==== design/ouv_params.svh ====
// Register offsets, field positions, reset values and timing counts for the output-low supervisor.
`ifndef OUV_PARAMS_SVH
`define OUV_PARAMS_SVH
`define OUV_ADDR_WARN       8'h43
`define OUV_ADDR_FAULT      8'h44
`define OUV_ADDR_ACTION     8'h45
`define OUV_ADDR_STATUS     8'h7a
`define OUV_RESP_HI         7
`define OUV_RESP_LO         6
`define OUV_RETRY_HI        5
`define OUV_RETRY_LO        3
`define OUV_TIME_HI         2
`define OUV_TIME_LO         0
`define OUV_WARN_RESET      16'h0000
`define OUV_FAULT_RESET     16'h0000
`define OUV_ACTION_RESET    8'h80
`define OUV_RETRY_NONE      3'h0
`define OUV_RETRY_FOREVER   3'h7
`define OUV_STAT_WARN_BIT   5
`define OUV_STAT_FAULT_BIT  4
`define OUV_RESTART_CYCLES  16'h0010
`endif

// ==== design/ouv_pkg.sv ====
// Types shared by the output-low supervisor.
package ouv_pkg;
  typedef enum logic [1:0] {
    OUV_RESP_IGNORE,
    OUV_RESP_DELAY,
    OUV_RESP_SHUTDOWN,
    OUV_RESP_WHILE_PRESENT
  } ouv_resp_e;
  typedef enum logic [2:0] {
    OUV_ST_RUN,
    OUV_ST_DELAY,
    OUV_ST_OFF_WAIT,
    OUV_ST_RESTART,
    OUV_ST_LATCHED,
    OUV_ST_HOLD_OFF
  } ouv_state_e;
  typedef logic [15:0] ouv_volt_t;
endpackage

// ==== design/ouv_unit_timer.sv ====
// Counts delay units: a span of units, each unit a number of clock cycles.
`timescale 1ns/1ps
`include "ouv_params.svh"
module ouv_unit_timer (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  // Control
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [7:0]  units,
  input  wire logic [15:0] unitCycles,
  // Status
  output logic             done
);
  logic [15:0] cycleCnt_ff;
  logic [7:0]  unitCnt_ff;
  logic        run_ff;
  logic        done_ff;

  assign done = done_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cycleCnt_ff <= 16'h0000;
      unitCnt_ff  <= 8'h00;
      run_ff      <= 1'b0;
      done_ff     <= 1'b0;
    end else if (clkEn) begin
      done_ff <= 1'b0;
      if (abort) begin
        run_ff <= 1'b0;
      end else if (start) begin
        run_ff      <= 1'b1;
        cycleCnt_ff <= 16'h0001;
        unitCnt_ff  <= 8'h01;
      end else if (run_ff) begin
        if (cycleCnt_ff >= unitCycles) begin
          cycleCnt_ff <= 16'h0001;
          if (unitCnt_ff >= units) begin
            run_ff  <= 1'b0;
            done_ff <= 1'b1;
          end else begin
            unitCnt_ff <= unitCnt_ff + 8'h01;
          end
        end else begin
          cycleCnt_ff <= cycleCnt_ff + 16'h0001;
        end
      end
    end
  end
endmodule

// ==== design/ouv_supervisor.sv ====
// Output under-voltage supervisor: thresholds, fault response, retries and output gating.
// Function
// - Host-programmable 16-bit unsigned warning threshold.
// - Host-programmable 16-bit unsigned fault threshold.
// - Response 00 ignores the fault; output keeps running.
// - Response 01 runs for the delay, then applies retry setting if fault persists.
// - Response 10 disables output at once, then follows the retry setting.
// - Response 11 disables output only while the fault is present.
// - Restart attempts number as the retry field says.
// - Retry 000 makes no restart; output stays off until fault cleared.
// - Retry 111 retries without limit.
// - Retry 001 makes one restart, then stays off until cleared.
// - Restart attempts are spaced by delay count times the delay unit.
// - Latched fault clears by status clear, clear-all, reset, off-on cycle, bias loss.
// - Retry 100 to 110 make four to six restarts, then stay off.
// - Endless retrying stops on off command, bias loss or another shutdown fault.
// - Delay count decodes to 1,2,4,8,16,32,64,128 units of the unit setting.
`timescale 1ns/1ps
`include "ouv_params.svh"
module ouv_supervisor (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire logic            clkEn,
  // Register port
  input  wire logic            regWrite,
  input  wire logic            regRead,
  input  wire logic [7:0]      regAddr,
  input  wire logic [15:0]     regWdata,
  output logic      [15:0]     regRdata,
  output logic                 regAck,
  // Fault clearing and shutdown events
  input  wire logic            clearFaults,
  input  wire logic            statusClear,
  input  wire logic            outputCmdOn,
  input  wire logic            biasGood,
  input  wire logic            otherShutdown,
  // Delay unit and measurement
  input  wire logic [15:0]     delayUnitCycles,
  input  wire ouv_pkg::ouv_volt_t measuredVout,
  // Outputs
  output logic                 outputEnable,
  output logic                 underWarn,
  output logic                 underFault,
  output logic                 faultLatched
);
  import ouv_pkg::*;

  ouv_volt_t  warnThr_ff;
  ouv_volt_t  faultThr_ff;
  logic [7:0] action_ff;
  logic [15:0] rdata_ff;
  logic       ack_ff;
  ouv_state_e state_ff;
  ouv_state_e nxt_state;
  logic [2:0] attempts_ff;
  logic [2:0] nxt_attempts;
  logic       warn_ff;
  logic       fault_ff;
  logic       latched_ff;
  logic       enable_ff;
  logic       cmdOnPrev_ff;
  logic       timerStart;
  logic       timerAbort;
  logic       timerDone;
  logic       restartTimerDone;
  logic [15:0] restartCnt_ff;
  logic       offOnCycle;
  logic       clearAll;
  logic       stopAll;
  logic       faultArmed;
  ouv_resp_e  resp;
  logic [2:0] retries;
  logic [7:0] units;

  function automatic logic [7:0] decodeUnits(input logic [2:0] code);
    case (code)
      3'h0: decodeUnits = 8'h01;
      3'h1: decodeUnits = 8'h02;
      3'h2: decodeUnits = 8'h04;
      3'h3: decodeUnits = 8'h08;
      3'h4: decodeUnits = 8'h10;
      3'h5: decodeUnits = 8'h20;
      3'h6: decodeUnits = 8'h40;
      default: decodeUnits = 8'h80;
    endcase
  endfunction

  // Builds the status word: warning and latched fault, all other bits zero.
  function automatic logic [15:0] statusWord(input logic warn, input logic latched);
    statusWord                      = 16'h0000;
    statusWord[`OUV_STAT_WARN_BIT]  = warn;
    statusWord[`OUV_STAT_FAULT_BIT] = latched;
  endfunction

  assign resp    = ouv_resp_e'(action_ff[`OUV_RESP_HI:`OUV_RESP_LO]);
  assign retries = action_ff[`OUV_RETRY_HI:`OUV_RETRY_LO];
  assign units   = decodeUnits(action_ff[`OUV_TIME_HI:`OUV_TIME_LO]);

  assign offOnCycle = outputCmdOn && !cmdOnPrev_ff;
  assign clearAll   = clearFaults || statusClear || offOnCycle || !biasGood;
  assign stopAll    = !outputCmdOn || !biasGood || otherShutdown;
  // A fault only counts while the output is commanded on and bias is present.
  assign faultArmed = fault_ff && outputCmdOn && biasGood;

  assign regRdata     = rdata_ff;
  assign regAck       = ack_ff;
  assign outputEnable = enable_ff;
  assign underWarn    = warn_ff;
  assign underFault   = fault_ff;
  assign faultLatched = latched_ff;

  // Every process below holds its state while clkEn is low.
  // Host register writes.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      warnThr_ff  <= `OUV_WARN_RESET;
      faultThr_ff <= `OUV_FAULT_RESET;
      action_ff   <= `OUV_ACTION_RESET;
    end else if (clkEn && regWrite) begin
      if (regAddr == `OUV_ADDR_WARN) begin
        warnThr_ff <= regWdata;
      end else if (regAddr == `OUV_ADDR_FAULT) begin
        faultThr_ff <= regWdata;
      end else if (regAddr == `OUV_ADDR_ACTION) begin
        action_ff <= regWdata[7:0];
      end
    end
  end

  // Host register reads; unmapped addresses read zero.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 16'h0000;
      ack_ff   <= 1'b0;
    end else if (clkEn) begin
      ack_ff <= regRead || regWrite;
      if (regRead) begin
        if (regAddr == `OUV_ADDR_WARN) begin
          rdata_ff <= warnThr_ff;
        end else if (regAddr == `OUV_ADDR_FAULT) begin
          rdata_ff <= faultThr_ff;
        end else if (regAddr == `OUV_ADDR_ACTION) begin
          rdata_ff <= {8'h00, action_ff};
        end else if (regAddr == `OUV_ADDR_STATUS) begin
          rdata_ff <= statusWord(warn_ff, latched_ff);
        end else begin
          rdata_ff <= 16'h0000;
        end
      end
    end
  end

  // Threshold comparison.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      warn_ff      <= 1'b0;
      fault_ff     <= 1'b0;
      cmdOnPrev_ff <= 1'b0;
    end else if (clkEn) begin
      warn_ff      <= measuredVout < warnThr_ff;
      fault_ff     <= measuredVout < faultThr_ff;
      cmdOnPrev_ff <= outputCmdOn;
    end
  end

  // Latched fault flag; a new fault wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      latched_ff <= 1'b0;
    end else if (clkEn) begin
      if (faultArmed && resp != OUV_RESP_IGNORE) begin
        latched_ff <= 1'b1;
      end else if (clearAll) begin
        latched_ff <= 1'b0;
      end
    end
  end

  // Settle time after a restart before the output counts as running.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      restartCnt_ff <= 16'h0000;
    end else if (clkEn) begin
      if (state_ff != OUV_ST_RESTART) begin
        restartCnt_ff <= 16'h0000;
      end else if (!restartTimerDone) begin
        restartCnt_ff <= restartCnt_ff + 16'h0001;
      end
    end
  end
  assign restartTimerDone = restartCnt_ff >= `OUV_RESTART_CYCLES;

  ouv_unit_timer uTimer (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .clkEn      (clkEn),
    .start      (timerStart),
    .abort      (timerAbort),
    .units      (units),
    .unitCycles (delayUnitCycles),
    .done       (timerDone)
  );

  // Response state machine.
  always_comb begin
    nxt_state    = state_ff;
    nxt_attempts = attempts_ff;
    timerStart   = 1'b0;
    timerAbort   = 1'b0;
    case (state_ff)
      OUV_ST_RUN: begin
        nxt_attempts = 3'h0;
        if (faultArmed) begin
          case (resp)
            OUV_RESP_IGNORE: nxt_state = OUV_ST_RUN;
            OUV_RESP_DELAY: begin
              nxt_state  = OUV_ST_DELAY;
              timerStart = 1'b1;
            end
            OUV_RESP_SHUTDOWN: begin
              nxt_state  = OUV_ST_OFF_WAIT;
              timerStart = 1'b1;
            end
            default: nxt_state = OUV_ST_HOLD_OFF;
          endcase
        end
      end
      OUV_ST_DELAY: begin
        if (!fault_ff) begin
          nxt_state  = OUV_ST_RUN;
          timerAbort = 1'b1;
        end else if (timerDone) begin
          nxt_state  = OUV_ST_OFF_WAIT;
          timerStart = 1'b1;
        end
      end
      OUV_ST_OFF_WAIT: begin
        if (retries == `OUV_RETRY_NONE) begin
          nxt_state = OUV_ST_LATCHED;
        end else if (retries != `OUV_RETRY_FOREVER && attempts_ff >= retries) begin
          nxt_state = OUV_ST_LATCHED;
        end else if (timerDone) begin
          nxt_state = OUV_ST_RESTART;
          if (retries != `OUV_RETRY_FOREVER) begin
            nxt_attempts = attempts_ff + 3'h1;
          end
        end
      end
      OUV_ST_RESTART: begin
        if (fault_ff) begin
          nxt_state  = OUV_ST_OFF_WAIT;
          timerStart = 1'b1;
        end else if (restartTimerDone) begin
          nxt_state = OUV_ST_RUN;
        end
      end
      OUV_ST_HOLD_OFF: begin
        if (!fault_ff) begin
          nxt_state = OUV_ST_RUN;
        end
      end
      default: begin
        nxt_state = OUV_ST_LATCHED;
      end
    endcase
    if (clearAll && state_ff != OUV_ST_RUN) begin
      nxt_state    = OUV_ST_RUN;
      nxt_attempts = 3'h0;
      timerAbort   = 1'b1;
      timerStart   = 1'b0;
    end else if (stopAll && state_ff != OUV_ST_RUN && state_ff != OUV_ST_LATCHED) begin
      nxt_state  = OUV_ST_LATCHED;
      timerAbort = 1'b1;
      timerStart = 1'b0;
    end
  end

  // State and attempt registers.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff    <= OUV_ST_RUN;
      attempts_ff <= 3'h0;
    end else if (clkEn) begin
      state_ff    <= nxt_state;
      attempts_ff <= nxt_attempts;
    end
  end

  // Output enable gating.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_ff <= 1'b0;
    end else if (clkEn) begin
      enable_ff <= outputCmdOn && biasGood && !otherShutdown &&
                   (nxt_state == OUV_ST_RUN || nxt_state == OUV_ST_DELAY ||
                    nxt_state == OUV_ST_RESTART);
    end
  end
endmodule

// ==== tb/ouv_supervisor_checker.sv ====
// Port assertions for the output-low supervisor.
`timescale 1ns/1ps
module ouv_supervisor_checker (
  // Clock, reset and register port
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        clkEn,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regAck,
  // Events, measurement and outputs
  input wire logic        clearFaults,
  input wire logic        statusClear,
  input wire logic        outputCmdOn,
  input wire logic        biasGood,
  input wire logic        otherShutdown,
  input wire ouv_pkg::ouv_volt_t measuredVout,
  input wire logic        outputEnable,
  input wire logic        underWarn,
  input wire logic        underFault,
  input wire logic        faultLatched
);
  import ouv_pkg::*;
  logic [15:0] warnThr;
  logic [15:0] faultThr;
  logic [7:0]  act;
  logic        live;
  // Shadow copies of the written thresholds and action.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      warnThr <= 16'h0000;
      faultThr <= 16'h0000;
      act <= 8'h80;
    end else if (clkEn && regWrite && regAddr == 8'h43) begin
      warnThr <= regWdata;
    end else if (clkEn && regWrite && regAddr == 8'h44) begin
      faultThr <= regWdata;
    end else if (clkEn && regWrite && regAddr == 8'h45) begin
      act <= regWdata[7:0];
    end
  end
  assign live = outputCmdOn && biasGood && !otherShutdown;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  warn_compare_a: assert property ($past(clkEn) |->
    underWarn == ($past(measuredVout) < $past(warnThr)))
    else $error("warning flag wrong");
  fault_compare_a: assert property ($past(clkEn) |->
    underFault == ($past(measuredVout) < $past(faultThr)))
    else $error("fault flag wrong");
  reg_ack_a: assert property ($past(clkEn) |-> regAck == $past(regWrite || regRead))
    else $error("register ack wrong");
  ignore_keeps_a: assert property ((act[7:6] == 2'b00 && $past(act[7:6]) == 2'b00
    && live && $past(live)) |-> !$fell(outputEnable))
    else $error("ignore mode dropped output");
  shut_at_once_a: assert property (($rose(underFault) && act[7:6] == 2'b10 && live
    && outputEnable) |=> (!outputEnable && faultLatched))
    else $error("shutdown late");
  off_while_a: assert property ((underFault && $past(underFault) && act[7:6] == 2'b11
    && live) |-> ##1 !outputEnable)
    else $error("output on during fault");
  resume_after_a: assert property (($fell(underFault) && act[7:6] == 2'b11 && live)
    |-> ##[1:3] outputEnable)
    else $error("output not resumed");
  cmd_off_a: assert property (!outputCmdOn [*2] |-> !outputEnable)
    else $error("output on while commanded off");
  clear_latch_a: assert property (((clearFaults || statusClear) && !underFault)
    |=> !faultLatched)
    else $error("latch not cleared");
  latch_holds_a: assert property ((faultLatched && !clearFaults && !statusClear && live
    && $past(outputCmdOn)) |=> faultLatched)
    else $error("latch lost");
  cover property ($fell(outputEnable) && act[7:6] == 2'b10);
  cover property ($rose(outputEnable) && act[5:3] == 3'b111);
  cover property ($fell(faultLatched));
endmodule

// ==== tb/ouv_host_model.sv ====
// Host model that reaches the supervisor registers with one-cycle strobes.
`timescale 1ns/1ps
module ouv_host_model (
  // Register port
  input  wire logic        clk_sys,
  input  wire logic        regAck,
  input  wire logic [15:0] regRdata,
  output logic             regWrite = 1'b0,
  output logic             regRead = 1'b0,
  output logic [7:0]       regAddr = 8'h00,
  output logic [15:0]      regWdata = 16'h0000
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    @(posedge clk_sys);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (regAck !== 1'b1 && n < 4);
    q = regRdata;
  endtask
endmodule

// ==== tb/ouv_supervisor_tb.sv ====
// Testbench for the output-low supervisor.
`timescale 1ns/1ps
module ouv_supervisor_tb;
  import ouv_pkg::*;
  logic clk_sys = 0, reset_n = 0, clkEn = 1, clearFaults = 0, statusClear = 0;
  logic outputCmdOn = 1, biasGood = 1, otherShutdown = 0;
  logic regWrite, regRead, regAck, outputEnable, underWarn, underFault, faultLatched;
  logic [7:0]  regAddr;
  logic [15:0] regWdata, regRdata, q;
  logic [15:0] delayUnitCycles = 16'h0004;
  ouv_volt_t   measuredVout = 16'hffff;
  int          fail_count = 0, checked = 0, cycles = 0, n, t;
  always #12.5 clk_sys = ~clk_sys;
  ouv_supervisor i_ouv_supervisor (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .clkEn           (clkEn),
    .regWrite        (regWrite),
    .regRead         (regRead),
    .regAddr         (regAddr),
    .regWdata        (regWdata),
    .regRdata        (regRdata),
    .regAck          (regAck),
    .clearFaults     (clearFaults),
    .statusClear     (statusClear),
    .outputCmdOn     (outputCmdOn),
    .biasGood        (biasGood),
    .otherShutdown   (otherShutdown),
    .delayUnitCycles (delayUnitCycles),
    .measuredVout    (measuredVout),
    .outputEnable    (outputEnable),
    .underWarn       (underWarn),
    .underFault      (underFault),
    .faultLatched    (faultLatched)
  );
  ouv_host_model i_ouv_host_model (
    .clk_sys  (clk_sys),
    .regAck   (regAck),
    .regRdata (regRdata),
    .regWrite (regWrite),
    .regRead  (regRead),
    .regAddr  (regAddr),
    .regWdata (regWdata)
  );
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    i_ouv_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    i_ouv_host_model.xfer(1'b0, a, 16'h0000, q);
    check("read", q, e);
  endtask
  task automatic setv(ouv_volt_t v);
    @(posedge clk_sys);
    measuredVout <= v;
  endtask
  task automatic clr();
    setv(16'hffff);
    cyc(2);
    clearFaults <= 1'b1;
    cyc(1);
    clearFaults <= 1'b0;
    cyc(3);
  endtask
  task automatic rises(int k, output int r);
    logic p;
    r = 0;
    p = outputEnable;
    repeat (k) begin
      @(negedge clk_sys);
      if (outputEnable && !p) r++;
      p = outputEnable;
    end
  endtask
  task automatic t_regs();
    rd(8'h45, 16'h0080);
    wr(8'h43, 16'h1000);
    wr(8'h44, 16'h0800);
    wr(8'h45, 16'h12c5);
    wr(8'h7a, 16'hffff);
    rd(8'h43, 16'h1000);
    rd(8'h44, 16'h0800);
    rd(8'h45, 16'h00c5);
    rd(8'h7a, 16'h0000);
    rd(8'h10, 16'h0000);
  endtask
  task automatic t_levels();
    setv(16'h0900);
    cyc(3);
    check("warn", underWarn, 1);
    check("fault", underFault, 0);
    rd(8'h7a, 16'h0020);
    setv(16'h07ff);
    cyc(3);
    check("fault", underFault, 1);
    check("off", outputEnable, 0);
    setv(16'h1000);
    cyc(4);
    check("warn", underWarn, 0);
    check("on", outputEnable, 1);
    wr(8'h45, 16'h0000);
    setv(16'h0000);
    cyc(40);
    check("ignore", outputEnable, 1);
    wr(8'h45, 16'h0043);
    cyc(18);
    check("delay", outputEnable, 1);
    cyc(24);
    check("delay", outputEnable, 0);
    clr();
  endtask
  task automatic t_time();
    int u[7] = '{1, 2, 8, 16, 32, 64, 128};
    logic [2:0] c[7] = '{0, 1, 3, 4, 5, 6, 7};
    for (int i = 0; i < 7; i++) begin
      wr(8'h45, {8'h00, 5'b10001, c[i]});
      setv(16'h0000);
      t = 0;
      while (outputEnable === 1'b1 && t < 9) begin
        @(negedge clk_sys);
        t++;
      end
      t = 0;
      while (outputEnable !== 1'b1 && t < 700) begin
        @(negedge clk_sys);
        t++;
      end
      check("offtime", t >= 4 * u[i] && t <= 4 * u[i] + 4, 1);
      clr();
    end
  endtask
  task automatic t_retry();
    logic [2:0] r[5] = '{0, 1, 4, 5, 6};
    for (int i = 0; i < 5; i++) begin
      wr(8'h45, {8'h00, 2'b10, r[i], 3'b000});
      setv(16'h0000);
      rises(400, n);
      check("retries", n, r[i]);
      check("latched", faultLatched, 1);
      clr();
      check("cleared", outputEnable, 1);
    end
  endtask
  task automatic t_stop();
    wr(8'h45, 16'h00b8);
    setv(16'h0000);
    rises(300, n);
    check("endless", n > 8, 1);
    cyc(1);
    outputCmdOn <= 1'b0;
    rises(100, n);
    check("cmd off", n, 0);
    setv(16'hffff);
    cyc(2);
    outputCmdOn <= 1'b1;
    cyc(4);
    check("off-on", faultLatched, 0);
    check("off-on", outputEnable, 1);
    setv(16'h0000);
    cyc(5);
    otherShutdown <= 1'b1;
    rises(100, n);
    check("other", n, 0);
    setv(16'hffff);
    otherShutdown <= 1'b0;
    biasGood <= 1'b0;
    cyc(2);
    biasGood <= 1'b1;
    cyc(4);
    check("bias", faultLatched, 0);
    wr(8'h45, 16'h0080);
    setv(16'h0000);
    cyc(4);
    setv(16'hffff);
    cyc(2);
    statusClear <= 1'b1;
    cyc(1);
    statusClear <= 1'b0;
    cyc(3);
    check("status", faultLatched, 0);
    check("status", outputEnable, 1);
  endtask
  task automatic t_freeze();
    @(posedge clk_sys);
    clkEn <= 1'b0;
    setv(16'h0000);
    cyc(4);
    check("frozen", underFault, 0);
    check("frozen", outputEnable, 1);
    clkEn <= 1'b1;
    cyc(3);
    check("thawed", underFault, 1);
    check("thawed", outputEnable, 0);
    clr();
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    cyc(4);
    reset_n <= 1'b1;
    t_regs();
    t_levels();
    t_time();
    t_retry();
    t_stop();
    t_freeze();
    finish_test();
  end
endmodule
bind ouv_supervisor ouv_supervisor_checker i_ouv_supervisor_checker (
  .clk_sys       (clk_sys),
  .reset_n       (reset_n),
  .clkEn         (clkEn),
  .regWrite      (regWrite),
  .regRead       (regRead),
  .regAddr       (regAddr),
  .regWdata      (regWdata),
  .regAck        (regAck),
  .clearFaults   (clearFaults),
  .statusClear   (statusClear),
  .outputCmdOn   (outputCmdOn),
  .biasGood      (biasGood),
  .otherShutdown (otherShutdown),
  .measuredVout  (measuredVout),
  .outputEnable  (outputEnable),
  .underWarn     (underWarn),
  .underFault    (underFault),
  .faultLatched  (faultLatched)
);
